/* sim/scr_partner.sv */
// behavioural spi slave on the far side of the serial pins
`timescale 1ns/1ns
module scr_partner (
  input wire logic ref_clk_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  input wire logic [7:0] tx_byte_i,
  output logic miso_o,
  output logic [7:0] rx_byte_o
);
  logic [2:0] cnt = 3'h0;
  logic junk = 1'b0;
  initial rx_byte_o = 8'h00;
  // unselected line toggles so a stale level never passes for data
  always @(posedge ref_clk_i) junk <= ~junk;
  always @(posedge sel_n_i) cnt <= 3'h0;
  always @(posedge sck_i) rx_byte_o <= {rx_byte_o[6:0], mosi_i};
  // msb first, next bit shown right after each falling serial clock
  always @(negedge sck_i) cnt <= cnt + 3'h1;
  assign miso_o = sel_n_i ? junk : tx_byte_i[3'h7 - cnt];
endmodule // scr_partner

/* sim/tb_top.sv */
// self-checking bench for the spi control and clock-rate block
`timescale 1ns/1ns
module tb_top;
  logic ref_clk_i, resetn_i, wr, rd, men, ss_drv, sck, mosi, ss_o, ss_oe, irq, miso, rise_seen, sck_any, sck_prev;
  logic [7:0] addr, wdata, rdata, ptx, prx, div, rv, txb;
  logic [1:0] ml [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int err_total, checks, gap;
  logic [7:0] exp_q [$];
  wire ss_line = ss_oe ? ss_o : ss_drv;
  scr_core scr_core_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .master_enable_i(men), .slave_select_pin_i(ss_line), .miso_i(miso), .sck_o(sck),
    .mosi_o(mosi), .slave_select_pin_o(ss_o), .slave_select_pin_oe_o(ss_oe), .irq_o(irq));
  scr_partner scr_partner_i (.ref_clk_i(ref_clk_i), .sck_i(sck), .mosi_i(mosi), .sel_n_i(ss_line),
    .tx_byte_i(ptx), .miso_o(miso), .rx_byte_o(prx));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
      begin
        err_total++;
        $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
  endtask
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_done();
    rv = 8'h00;
    for (int n = 0; n < 200 && rv[7] !== 1'b1; n++) br(8'h00, rv);
  endtask
  task automatic results();
    $display("mismatches %0d of %0d checks", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // sampled mid-cycle so the registered serial clock has settled
  always @(negedge ref_clk_i)
  begin
    gap = gap + 1;
    if (sck === 1'b1 && sck_prev === 1'b0)
    begin
      if (rise_seen)
        check("sck period", gap, 2 * (div + 1));
      rise_seen = 1'b1;
      gap = 0;
    end
    if (sck)
      sck_any = 1'b1;
    sck_prev = sck;
  end
  initial
  begin
    #800000;
    err_total++;
    results();
  end
  initial
  begin
    {resetn_i, wr, rd, men, rise_seen, sck_any} = 6'h00;
    {addr, wdata, ptx, div, txb} = 40'h0;
    ss_drv = 1'b1;
    {err_total, checks, gap} = 0;
    void'($urandom(32'h580C));
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    br(8'h00, rv);
    check("ctrl reset", rv, 8'h06);
    br(8'h01, rv);
    check("divider reset", rv, 8'h00);
    br(8'h77, rv);
    check("unmapped read", rv, 8'h00);
    @(posedge ref_clk_i);
    men <= 1'b1;
    ss_drv <= 1'b0;
    // mode 01 last: set wins over clear while the fault condition holds
    for (int i = 0; i < 4; i++)
    begin
      bw(8'h00, {4'hF, ml[i], 2'b01});
      br(8'h00, rv);
      check("ctrl mode", rv, {(ml[i] == 2'h1) ? 4'h2 : 4'h0, ml[i], 2'b11});
      check("select oe", ss_oe, ml[i][1]);
      if (ml[i][1])
        check("select out", ss_o, ml[i][0]);
    end
    bw(8'h02, 8'h20);
    br(8'h02, rv);
    check("irq fault", irq, 1'b1);
    @(posedge ref_clk_i);
    ss_drv <= 1'b1;
    men <= 1'b0;
    div = 8'($urandom_range(3));
    ptx <= 8'($urandom);
    txb = 8'($urandom);
    bw(8'h01, div);
    bw(8'h00, 8'hF9);
    bw(8'h02, 8'h00);
    bw(8'h03, txb);
    br(8'h00, rv);
    check("txe after write", rv, 8'h09);
    @(posedge ref_clk_i);
    men <= 1'b1;
    rise_seen = 1'b0;
    wait_done();
    check("ctrl done", rv, 8'h8B);
    check("slave got", prx, txb);
    exp_q.push_back(ptx);
    @(posedge ref_clk_i);
    ptx <= 8'($urandom);
    rise_seen = 1'b0;
    txb = 8'($urandom);
    bw(8'h00, 8'h89);
    bw(8'h03, txb);
    bw(8'h03, ~txb);
    wait_done();
    check("ctrl collide", rv, 8'hDB);
    check("slave got 2", prx, txb);
    br(8'h03, rv);
    check("rx kept", rv, exp_q.pop_front());
    bw(8'h02, 8'hF0);
    br(8'h02, rv);
    check("irq on", irq, 1'b1);
    bw(8'h02, 8'h00);
    br(8'h02, rv);
    check("irq masked", irq, 1'b0);
    @(posedge ref_clk_i);
    sck_any = 1'b0;
    bw(8'h00, 8'hF8);
    bw(8'h03, 8'hA5);
    repeat (40) @(posedge ref_clk_i);
    check("sck disabled", sck_any, 1'b0);
    br(8'h00, rv);
    check("done disabled", rv[7], 1'b0);
    results();
  end
endmodule // tb_top

/* verilog/scr_core.sv */
// spi control/status, clock-rate divider and a master-mode byte shifter
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

// Contract
// - a finished transfer sets transfer_done_flag, which stays until software clears it, and it may interrupt.
// - a data write while a byte is already pending or shifting sets write_collision_flag and may interrupt.
// - slave_select_pin low while master_enable is 1 and select_pin_mode is 01 sets mode_fault_flag.
// - the last bit entering the shifter while the receive buffer is unread sets receive_overrun_flag.
// - select_pin_mode 00 leaves the select pin unused, and 01 makes it an input; 01 is the reset default.
// - select_pin_mode 1x drives the select pin as an output carrying the low mode bit.
// - tx_buffer_empty falls on a data write that does not collide and rises when the byte moves into the shifter.
// - the master serial clock is core_clock divided by 2 times (clock_divisor plus one).
module scr_core (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic master_enable_i,
  input wire logic slave_select_pin_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic slave_select_pin_o,
  output logic slave_select_pin_oe_o,
  output logic irq_o
);
  scr_pkg::scr_regs_t q_r;
  scr_pkg::scr_regs_t q_nxt;
  scr_pkg::scr_bus_t bus;
  logic en;
  logic smd_hi;
  logic wr_data;
  logic load;
  logic last_bit;
  logic mode_fault_flag_ev;
  logic [7:0] ev;
  logic [7:0] ctrl_rd;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign en = q_r.ctrl[scr_pkg::BIT_EN];
  assign smd_hi = q_r.ctrl[scr_pkg::BIT_SMD1];
  assign wr_data = bus.wr && bus.addr[1:0] == scr_pkg::ADDR_DATA && bus.addr[7:2] == 6'h00;
  // a pending byte is launched only when the shifter is free and the port is a master
  assign load = en && master_enable_i && q_r.st == scr_pkg::ST_IDLE && !q_r.ctrl[scr_pkg::BIT_TXE];
  assign last_bit = q_r.st == scr_pkg::ST_HIGH && q_r.divcnt == 8'h00 && q_r.bitcnt == scr_pkg::BITS_LAST;
  assign mode_fault_flag_ev = en && master_enable_i && !slave_select_pin_i
    && q_r.ctrl[scr_pkg::BIT_SMD1:scr_pkg::BIT_SMD0] == scr_pkg::SMD_4WIRE_SLV;

  always_comb
  begin
    ev = 8'h00;
    ev[scr_pkg::BIT_DONE] = last_bit;
    ev[scr_pkg::BIT_WRITE_COLLISION_FLAG] = wr_data && (!q_r.ctrl[scr_pkg::BIT_TXE] || q_r.st != scr_pkg::ST_IDLE);
    ev[scr_pkg::BIT_MODE_FAULT_FLAG] = mode_fault_flag_ev;
    ev[scr_pkg::BIT_OVR] = last_bit && q_r.rx_full;
  end

  always_comb
  begin
    ctrl_rd = q_r.ctrl;
    ctrl_rd[scr_pkg::BIT_TXE] = q_r.ctrl[scr_pkg::BIT_TXE];
  end

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rdata = 8'h00;
    if (bus.wr && bus.addr[7:2] == 6'h00)
    begin
      case (bus.addr[1:0])
        scr_pkg::ADDR_CTRL:
        begin
          // flags clear by writing a one; tx_buffer_empty is read only
          q_nxt.ctrl[7:4] = q_r.ctrl[7:4] & ~bus.wdata[7:4];
          q_nxt.ctrl[scr_pkg::BIT_SMD1] = bus.wdata[scr_pkg::BIT_SMD1];
          q_nxt.ctrl[scr_pkg::BIT_SMD0] = bus.wdata[scr_pkg::BIT_SMD0];
          q_nxt.ctrl[scr_pkg::BIT_EN] = bus.wdata[scr_pkg::BIT_EN];
        end
        scr_pkg::ADDR_CKDIV: q_nxt.ckdiv = bus.wdata;
        scr_pkg::ADDR_IMASK: q_nxt.imask = bus.wdata & scr_pkg::FLAG_MASK;
        default:
        begin
          // a colliding write is dropped so the byte in flight is not corrupted
          if (!ev[scr_pkg::BIT_WRITE_COLLISION_FLAG])
          begin
            q_nxt.txbuf = bus.wdata;
            q_nxt.ctrl[scr_pkg::BIT_TXE] = 1'b0;
          end
        end
      endcase
    end
    if (bus.rd)
    begin
      if (bus.addr[7:2] != 6'h00)
        q_nxt.rdata = 8'h00;
      else
      begin
        case (bus.addr[1:0])
          scr_pkg::ADDR_CTRL: q_nxt.rdata = ctrl_rd;
          scr_pkg::ADDR_CKDIV: q_nxt.rdata = q_r.ckdiv;
          scr_pkg::ADDR_IMASK: q_nxt.rdata = q_r.imask;
          default:
          begin
            q_nxt.rdata = q_r.rxbuf;
            q_nxt.rx_full = 1'b0;
          end
        endcase
      end
    end
    // hardware set wins over a same-cycle software clear
    q_nxt.ctrl[7:4] = q_nxt.ctrl[7:4] | ev[7:4];
    case (q_r.st)
      scr_pkg::ST_IDLE:
      begin
        q_nxt.sck = 1'b0;
        if (load)
        begin
          q_nxt.shift = q_r.txbuf;
          q_nxt.ctrl[scr_pkg::BIT_TXE] = 1'b1;
          q_nxt.bitcnt = 4'h0;
          q_nxt.divcnt = q_r.ckdiv;
          q_nxt.st = scr_pkg::ST_LOW;
        end
      end
      scr_pkg::ST_LOW:
      begin
        // each half period lasts clock_divisor+1 core clocks
        if (q_r.divcnt == 8'h00)
        begin
          q_nxt.divcnt = q_r.ckdiv;
          q_nxt.sck = 1'b1;
          // sample on the rising edge but shift on the falling one, so mosi never moves
          // on the edge at which the far side samples it
          q_nxt.rx_bit = miso_i;
          q_nxt.st = scr_pkg::ST_HIGH;
        end
        else
          q_nxt.divcnt = q_r.divcnt - 8'h01;
      end
      scr_pkg::ST_HIGH:
      begin
        if (q_r.divcnt == 8'h00)
        begin
          q_nxt.divcnt = q_r.ckdiv;
          q_nxt.sck = 1'b0;
          q_nxt.shift = {q_r.shift[6:0], q_r.rx_bit};
          if (q_r.bitcnt == scr_pkg::BITS_LAST)
          begin
            q_nxt.rxbuf = {q_r.shift[6:0], q_r.rx_bit};
            q_nxt.rx_full = 1'b1;
            q_nxt.st = scr_pkg::ST_IDLE;
          end
          else
          begin
            q_nxt.bitcnt = q_r.bitcnt + 4'h1;
            q_nxt.st = scr_pkg::ST_LOW;
          end
        end
        else
          q_nxt.divcnt = q_r.divcnt - 8'h01;
      end
      default: q_nxt.st = scr_pkg::ST_IDLE;
    endcase
    // a transfer overrun keeps the old unread byte
    if (last_bit && q_r.rx_full)
      q_nxt.rxbuf = q_r.rxbuf;
    if (!en || !master_enable_i)
    begin
      q_nxt.st = scr_pkg::ST_IDLE;
      q_nxt.sck = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      q_r <= '0;
      q_r.st <= scr_pkg::ST_IDLE;
      q_r.ctrl <= scr_pkg::CTRL_RESET;
      q_r.ckdiv <= scr_pkg::CKDIV_RESET;
      q_r.imask <= scr_pkg::IMASK_RESET;
    end
    else
      q_r <= q_nxt;
  end

  assign rdata_o = q_r.rdata;
  assign sck_o = q_r.sck;
  assign mosi_o = q_r.shift[7];
  assign slave_select_pin_oe_o = en && smd_hi;
  assign slave_select_pin_o = smd_hi ? q_r.ctrl[scr_pkg::BIT_SMD0] : 1'b1;
  assign irq_o = |(q_r.ctrl & q_r.imask & scr_pkg::FLAG_MASK);

  done_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    last_bit |=> q_r.ctrl[scr_pkg::BIT_DONE])
    else $error("done flag not set");
  done_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.ctrl[scr_pkg::BIT_DONE] && !(bus.wr && bus.addr == 8'h00 && bus.wdata[7]) |=> q_r.ctrl[scr_pkg::BIT_DONE])
    else $error("done flag cleared without write");
  write_collision_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_data && q_r.st != scr_pkg::ST_IDLE |=> q_r.ctrl[scr_pkg::BIT_WRITE_COLLISION_FLAG])
    else $error("collision not flagged");
  mode_fault_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    mode_fault_flag_ev |=> q_r.ctrl[scr_pkg::BIT_MODE_FAULT_FLAG])
    else $error("mode fault not flagged");
  ovr_set_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    last_bit && q_r.rx_full |=> q_r.ctrl[scr_pkg::BIT_OVR])
    else $error("overrun not flagged");
  ss_input_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !smd_hi |-> !slave_select_pin_oe_o)
    else $error("select pin driven in input mode");
  ss_drive_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    en && smd_hi |-> slave_select_pin_oe_o && slave_select_pin_o == q_r.ctrl[scr_pkg::BIT_SMD0])
    else $error("select pin output wrong");
  txe_fall_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_data && !ev[scr_pkg::BIT_WRITE_COLLISION_FLAG] |=> !q_r.ctrl[scr_pkg::BIT_TXE])
    else $error("tx empty not cleared");
  txe_rise_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    load |=> q_r.ctrl[scr_pkg::BIT_TXE] && q_r.st == scr_pkg::ST_LOW)
    else $error("tx empty not set on load");
  half_period_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.st == scr_pkg::ST_LOW && q_r.divcnt == 8'h00 && en && master_enable_i
    |=> q_r.sck && q_r.divcnt == q_r.ckdiv)
    else $error("divider reload wrong");
  disable_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !en |=> q_r.st == scr_pkg::ST_IDLE && !sck_o)
    else $error("port active while disabled");

  // flags: nothing but their own event sets them, and only a one written clears them
  done_only_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !last_bit && !q_r.ctrl[scr_pkg::BIT_DONE] |=> !q_r.ctrl[scr_pkg::BIT_DONE])
    else $error("done flag set without transfer");
  done_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.wr && bus.addr == 8'h00 && bus.wdata[7] && !last_bit |=> !q_r.ctrl[scr_pkg::BIT_DONE])
    else $error("done flag not cleared");
  done_irq_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    last_bit && q_r.imask[scr_pkg::BIT_DONE] && !(bus.wr && bus.addr == 8'h02) |=> irq_o)
    else $error("done interrupt missing");
  bitcnt_range_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.st != scr_pkg::ST_IDLE |-> q_r.bitcnt <= scr_pkg::BITS_LAST)
    else $error("bit count out of range");

  write_collision_flag_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.ctrl[scr_pkg::BIT_WRITE_COLLISION_FLAG] && !(bus.wr && bus.addr == 8'h00 && bus.wdata[6]) |=> q_r.ctrl[scr_pkg::BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag lost");
  write_collision_flag_only_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !wr_data && !q_r.ctrl[scr_pkg::BIT_WRITE_COLLISION_FLAG] |=> !q_r.ctrl[scr_pkg::BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag set without write");
  write_collision_flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.wr && bus.addr == 8'h00 && bus.wdata[6] |=> !q_r.ctrl[scr_pkg::BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag not cleared");
  write_collision_flag_drop_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ev[scr_pkg::BIT_WRITE_COLLISION_FLAG] |=> q_r.txbuf == $past(q_r.txbuf))
    else $error("colliding write reached buffer");

  mode_fault_flag_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.ctrl[scr_pkg::BIT_MODE_FAULT_FLAG] && !(bus.wr && bus.addr == 8'h00 && bus.wdata[5]) |=> q_r.ctrl[scr_pkg::BIT_MODE_FAULT_FLAG])
    else $error("mode fault flag lost");
  mode_fault_flag_only_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !mode_fault_flag_ev && !q_r.ctrl[scr_pkg::BIT_MODE_FAULT_FLAG] |=> !q_r.ctrl[scr_pkg::BIT_MODE_FAULT_FLAG])
    else $error("mode fault flag set without fault");
  mode_fault_flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.wr && bus.addr == 8'h00 && bus.wdata[5] && !mode_fault_flag_ev |=> !q_r.ctrl[scr_pkg::BIT_MODE_FAULT_FLAG])
    else $error("mode fault flag not cleared");

  ovr_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.ctrl[scr_pkg::BIT_OVR] && !(bus.wr && bus.addr == 8'h00 && bus.wdata[4]) |=> q_r.ctrl[scr_pkg::BIT_OVR])
    else $error("overrun flag lost");
  ovr_only_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(last_bit && q_r.rx_full) && !q_r.ctrl[scr_pkg::BIT_OVR] |=> !q_r.ctrl[scr_pkg::BIT_OVR])
    else $error("overrun flag set without overrun");
  ovr_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.wr && bus.addr == 8'h00 && bus.wdata[4] && !last_bit |=> !q_r.ctrl[scr_pkg::BIT_OVR])
    else $error("overrun flag not cleared");
  ovr_keep_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    last_bit && q_r.rx_full |=> q_r.rxbuf == $past(q_r.rxbuf))
    else $error("unread byte overwritten");
  rx_capture_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    last_bit |=> q_r.rx_full)
    else $error("receive buffer not marked full");
  rx_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.rd && bus.addr == 8'h03 && !last_bit |=> !q_r.rx_full)
    else $error("receive buffer not freed by read");

  // select pin modes
  smd_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.wr && bus.addr == 8'h00 |=> q_r.ctrl[scr_pkg::BIT_SMD1:scr_pkg::BIT_SMD0] == $past(bus.wdata[3:2]))
    else $error("select mode not written");
  ss_3wire_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.ctrl[scr_pkg::BIT_SMD1:scr_pkg::BIT_SMD0] == scr_pkg::SMD_3WIRE |-> !mode_fault_flag_ev)
    else $error("fault seen with select pin unused");
  ss_master_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    smd_hi |-> !mode_fault_flag_ev)
    else $error("fault seen in single master mode");

  // transmit buffer state
  txe_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.ctrl[scr_pkg::BIT_TXE] && !wr_data |=> q_r.ctrl[scr_pkg::BIT_TXE])
    else $error("tx empty dropped without write");
  txe_low_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !q_r.ctrl[scr_pkg::BIT_TXE] && !load |=> !q_r.ctrl[scr_pkg::BIT_TXE])
    else $error("tx empty rose without load");

  // serial clock timing
  sck_fall_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.st == scr_pkg::ST_HIGH && q_r.divcnt == 8'h00 && en && master_enable_i |=> !q_r.sck)
    else $error("serial clock did not fall");
  divcnt_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.st != scr_pkg::ST_IDLE && q_r.divcnt != 8'h00 && en && master_enable_i
    |=> q_r.divcnt == $past(q_r.divcnt) - 8'h01)
    else $error("divider did not count down");
  sck_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.st == scr_pkg::ST_IDLE |-> !q_r.sck)
    else $error("serial clock high while idle");
  mosi_stable_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q_r.st == scr_pkg::ST_LOW && en && master_enable_i |=> $stable(mosi_o))
    else $error("mosi moved on sampling edge");
  div_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.rd && bus.addr == 8'h01 |=> rdata_o == $past(q_r.ckdiv))
    else $error("divider read back wrong");

  // enable
  men_stop_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !master_enable_i |=> q_r.st == scr_pkg::ST_IDLE)
    else $error("shifter ran outside master mode");
  en_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    bus.wr && bus.addr == 8'h00 |=> en == $past(bus.wdata[scr_pkg::BIT_EN]))
    else $error("port enable not written");
  ss_off_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !en |-> !slave_select_pin_oe_o)
    else $error("select pin driven while disabled");
  xfer_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) last_bit);
  ovr_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) ev[scr_pkg::BIT_OVR]);
  write_collision_flag_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) ev[scr_pkg::BIT_WRITE_COLLISION_FLAG]);
  mode_fault_flag_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) mode_fault_flag_ev);
  load_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) load);
endmodule // scr_core

/* verilog/scr_pkg.sv */
// package: register map, field layout and state types for the spi control and clock-rate block
package scr_pkg;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CKDIV = 2'h1;
  localparam logic [1:0] ADDR_IMASK = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [7:0] CKDIV_RESET = 8'h00;
  localparam logic [7:0] IMASK_RESET = 8'h00;
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_MODE_FAULT_FLAG = 5;
  localparam int BIT_OVR = 4;
  localparam int BIT_SMD1 = 3;
  localparam int BIT_SMD0 = 2;
  localparam int BIT_TXE = 1;
  localparam int BIT_EN = 0;
  localparam logic [7:0] FLAG_MASK = 8'hF0;
  localparam logic [1:0] SMD_3WIRE = 2'h0;
  localparam logic [1:0] SMD_4WIRE_SLV = 2'h1;
  localparam logic [3:0] BITS_LAST = 4'h7;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} scr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scr_bus_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic ss_out;
    logic ss_oe;
  } scr_pins_t;

  typedef struct packed {
    scr_state_t st;
    logic [7:0] ctrl;
    logic [7:0] ckdiv;
    logic [7:0] imask;
    logic [7:0] txbuf;
    logic [7:0] shift;
    logic [7:0] rxbuf;
    logic rx_full;
    logic [3:0] bitcnt;
    logic [7:0] divcnt;
    logic [7:0] rdata;
    logic sck;
    logic rx_bit;
  } scr_regs_t;
endpackage
